// File: dv/ulpi_link_model.sv
module ulpi_link_model
  import vendor_sense_pkg::*;
(
  // link clock
  input  wire logic       i_link_clk,
  // answers from the device
  input  wire logic       i_reg_ack,
  input  wire logic [7:0] i_reg_rdata,
  // immediate register requests
  output logic            o_reg_wr_stb,
  output logic            o_reg_rd_stb,
  output logic [5:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // idle bus
  initial begin
    o_reg_wr_stb = 1'b0;
    o_reg_rd_stb = 1'b0;
    o_reg_addr   = 6'h00;
    o_reg_wdata  = 8'h00;
  end
  // ==========================================================
  // immediate write and read; released lines show the inverse
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_link_clk);
    #1;
    o_reg_addr   = a;
    o_reg_wdata  = (a >= ADDR_SENSE_WR && a <= ADDR_SENSE_CLR) ? (d & 8'hdf) : d;
    o_reg_wr_stb = 1'b1;
    @(posedge i_link_clk);
    #1;
    o_reg_wr_stb = 1'b0;
    o_reg_addr   = ~o_reg_addr;
    o_reg_wdata  = ~o_reg_wdata;
    // let registered outputs follow the write
    @(posedge i_link_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic k);
    @(posedge i_link_clk);
    #1;
    o_reg_addr   = a;
    o_reg_rd_stb = 1'b1;
    @(posedge i_link_clk);
    #1;
    k            = i_reg_ack;
    d            = i_reg_rdata;
    o_reg_rd_stb = 1'b0;
    o_reg_addr   = ~o_reg_addr;
  endtask : rd
endmodule : ulpi_link_model

// File: dv/ulpi_vendor_id_sense_regs_tb.sv
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module ulpi_vendor_id_sense_regs_tb
  import vendor_sense_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SENSE_P = 20;
  // ==========================================================
  // signals
  logic       clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  logic       wr_stb, rd_stb, hit, ack, rise_en = 1'b0, fall_en = 1'b0, kit_en = 1'b0;
  logic       id_float, alt_int, audio_en, done, id_open = 1'b0, float_line_pullup_en = 1'b0;
  logic       hit_exp;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [2:0] conv_code = 3'h0, res_code;
  logic [1:0] boost;
  logic       k;
  int         error_cnt = 0, cmp_count = 0, cyc = 0, n;
  // reference model: register contents kept as plain integers
  int         m_boost = 0, m_key = 0;
  logic [2:0] codes [7] = '{RES_ZERO, RES_75, RES_100K, RES_200K, RES_440K, RES_FLOATING,
                            RES_ERROR};
  logic [5:0] ra [8] = '{ADDR_LATCH, ADDR_BOOST, ADDR_AUDIO, ADDR_SENSE_WR, ADDR_SENSE_SET,
                         ADDR_SENSE_CLR, ADDR_VENDOR_LO, ADDR_VENDOR_HI};
  always #10 clk = ~clk;
  always #6 link_clk = ~link_clk;
  // the id line only reads floating once the link has turned on its pull-up
  assign id_float = float_line_pullup_en && id_open;
  assign hit_exp  = (addr == ADDR_LATCH) || ((addr >= ADDR_VENDOR_LO) && (addr <= ADDR_VENDOR_HI));
  // ==========================================================
  // design and link partner
  ulpi_vendor_id_sense_regs #(.SENSE_CYCLES_P(SENSE_P)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_link_clk(link_clk), .i_reg_wr_stb(wr_stb),
    .i_reg_rd_stb(rd_stb), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_hit(hit),
    .o_reg_rdata(rdata), .o_reg_ack(ack), .i_float_rise_irq_en(rise_en),
    .i_float_fall_irq_en(fall_en), .i_kit_sense_irq_en(kit_en), .i_id_floating(id_float),
    .i_conv_code(conv_code), .o_alt_int(alt_int), .o_boost(boost),
    .o_headset_audio_en(audio_en), .o_sense_result_code(res_code), .o_sense_done(done));
  ulpi_link_model link (
    .i_link_clk(link_clk), .i_reg_ack(ack), .i_reg_rdata(rdata), .o_reg_wr_stb(wr_stb),
    .o_reg_rd_stb(rd_stb), .o_reg_addr(addr), .o_reg_wdata(wdata));
  // ==========================================================
  // helpers
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    link.rd(a, d, k);
    `CHK("ack", 1'b1, k)
    `CHK("rdata", e, d)
  endtask : rd_chk
  task automatic mwr(input logic [5:0] a, input logic [7:0] v);
    if (a == ADDR_BOOST) begin
      m_boost = v[BOOST_MSB:BOOST_LSB];
    end
    if (a == ADDR_AUDIO) begin
      m_key = v[3:0];
    end
    link.wr(a, v);
  endtask : mwr
  task automatic settle(input int c);
    repeat (c) @(posedge link_clk);
    #1;
  endtask : settle
  // mode 0 set alias with own enable, 1 load with kit enable, 2 no enable
  task automatic measure(input int mode, input logic [2:0] code, input logic [5:0] ra_s);
    logic irq;
    irq       = (mode == 0);
    conv_code = code;
    kit_en    = (mode == 1);
    link.wr(mode == 0 ? ADDR_SENSE_SET : ADDR_SENSE_WR, mode == 0 ? 8'h50 : 8'h10);
    link.rd(ADDR_SENSE_WR, d, k);
    `CHK("go", 1'b1, d[SENSE_GO_BIT])
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("wait", 1'b1, n >= SENSE_P && n < 400)
    link.rd(ADDR_KIT_STATUS, d, k);
    `CHK("status ack", 1'b0, k)
    `CHK("status keep", 1'b1, done)
    settle(2);
    `CHK("mirror", code, res_code)
    `CHK("alt_int", irq || kit_en, alt_int)
    rd_chk(ra_s, {1'b0, irq, 3'b001, code});
    settle(2);
    `CHK("done", 1'b0, done)
    rd_chk(ADDR_LATCH, (irq || kit_en) ? 8'h08 : 8'h00);
  endtask : measure
  // ==========================================================
  // address decode seen by every read
  always @(posedge link_clk) begin
    if (rd_stb === 1'b1) begin
      `CHK("hit", hit_exp, hit)
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    void'($urandom(32'h2fd1));
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    settle(5);
    foreach (ra[i]) rd_chk(ra[i], RESET_BYTE);
    link.rd(6'h22, d, k);
    `CHK("unmapped ack", 1'b0, k)
    for (int b = 0; b < 4; b++) begin
      d = $urandom;
      d[6:5] = b[1:0];
      mwr(ADDR_BOOST, d);
      `CHK("boost", 2'(m_boost), boost)
      rd_chk(ADDR_BOOST, {1'b0, 2'(m_boost), 5'h00});
    end
    d = {4'($urandom), AUDIO_KEY};
    mwr(ADDR_AUDIO, d);
    `CHK("audio", m_key == AUDIO_KEY, audio_en)
    rd_chk(ADDR_AUDIO, {4'h0, 4'(m_key)});
    mwr(ADDR_AUDIO, 8'hfb);
    `CHK("audio", m_key == AUDIO_KEY, audio_en)
    rd_chk(ADDR_AUDIO, {4'h0, 4'(m_key)});
    link.wr(ADDR_LATCH, 8'hff);
    rd_chk(ADDR_LATCH, 8'h00);
    // id floating is asynchronous; allow the synchroniser to catch up
    float_line_pullup_en = 1'b1;
    rise_en  = 1'b1;
    id_open  = 1'b1;
    settle(8);
    `CHK("alt_int", 1'b1, alt_int)
    rd_chk(ADDR_LATCH, 8'h01);
    rd_chk(ADDR_LATCH, 8'h00);
    settle(1);
    `CHK("alt_int", 1'b0, alt_int)
    id_open = 1'b0;
    settle(8);
    rd_chk(ADDR_LATCH, 8'h00);
    {rise_en, fall_en} = 2'b01;
    id_open = 1'b1;
    settle(8);
    id_open = 1'b0;
    settle(8);
    rd_chk(ADDR_LATCH, 8'h01);
    foreach (codes[i]) measure(i % 3, codes[i], ADDR_SENSE_WR + 6'(i % 3));
    link.wr(ADDR_SENSE_SET, 8'h40);
    link.wr(ADDR_SENSE_CLR, 8'h40);
    rd_chk(ADDR_SENSE_CLR, {5'h00, RES_ERROR});
    give_verdict();
  end
endmodule : ulpi_vendor_id_sense_regs_tb

// File: include/vendor_sense_pkg.sv
package vendor_sense_pkg;
  // ==========================================================
  // register addresses (ulpi immediate address space)
  localparam logic [5:0] ADDR_KIT_STATUS = 6'h20;
  localparam logic [5:0] ADDR_LATCH      = 6'h21;
  localparam logic [5:0] ADDR_VENDOR_LO  = 6'h30;
  localparam logic [5:0] ADDR_BOOST      = 6'h31;
  localparam logic [5:0] ADDR_AUDIO      = 6'h33;
  localparam logic [5:0] ADDR_SENSE_WR   = 6'h36;
  localparam logic [5:0] ADDR_SENSE_SET  = 6'h37;
  localparam logic [5:0] ADDR_SENSE_CLR  = 6'h38;
  localparam logic [5:0] ADDR_VENDOR_HI  = 6'h3f;

  // ==========================================================
  // field positions
  localparam int unsigned LATCH_FLOAT_BIT = 0;
  localparam int unsigned LATCH_SENSE_BIT = 3;
  localparam int unsigned BOOST_LSB       = 5;
  localparam int unsigned BOOST_MSB       = 6;
  localparam int unsigned SENSE_DONE_BIT  = 3;
  localparam int unsigned SENSE_GO_BIT    = 4;
  localparam int unsigned SENSE_RSVD_BIT  = 5;
  localparam int unsigned SENSE_IRQ_BIT   = 6;

  // ==========================================================
  // values and encodings
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [3:0] AUDIO_KEY     = 4'ha;
  localparam logic [1:0] BOOST_NOMINAL = 2'h0;
  localparam logic [1:0] BOOST_PLUS_111 = 2'h1;
  localparam logic [1:0] BOOST_PLUS_74 = 2'h2;
  localparam logic [1:0] BOOST_PLUS_37 = 2'h3;
  localparam logic [2:0] RES_ZERO      = 3'h0;
  localparam logic [2:0] RES_75        = 3'h1;
  localparam logic [2:0] RES_100K      = 3'h2;
  localparam logic [2:0] RES_200K      = 3'h3;
  localparam logic [2:0] RES_440K      = 3'h4;
  localparam logic [2:0] RES_FLOATING  = 3'h5;
  localparam logic [2:0] RES_ERROR     = 3'h7;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SENSE_TIME_NS = 282000;
  localparam int unsigned SENSE_CYCLES  = SENSE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SENSE_CNT_W   = 16;
endpackage : vendor_sense_pkg

// File: rtl/resistor_sense_timer.sv
module resistor_sense_timer
  import vendor_sense_pkg::*;
#(
  parameter int unsigned SENSE_CYCLES_P = SENSE_CYCLES
) (
  // core clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // launch event from the link domain
  input  wire logic       i_go_tgl,
  // converter code
  input  wire logic [2:0] i_conv_code,
  // completion back to the link domain
  output logic            o_done_tgl,
  output logic [2:0]      o_result_q
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_RUN  = 2'b10
  } state_type;

  localparam logic [SENSE_CNT_W-1:0] LAST_CNT = SENSE_CNT_W'(SENSE_CYCLES_P - 1);

  state_type              state_q, state_d;
  logic [SENSE_CNT_W-1:0] cnt_q, cnt_d;
  logic                   go_s1_q, go_s2_q, go_s3_q;
  logic [2:0]             code_s1_q, code_s2_q;
  logic                   done_tgl_q, done_tgl_d;
  logic [2:0]             result_q, result_d;
  logic                   go_edge;

  assign go_edge    = go_s2_q ^ go_s3_q;
  assign o_done_tgl = done_tgl_q;
  assign o_result_q = result_q;

  // ==========================================================
  // sequencer
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    done_tgl_d = done_tgl_q;
    result_d   = result_q;
    unique case (state_q)
      S_IDLE: begin
        if (go_edge) begin
          state_d = S_RUN;
          cnt_d   = LAST_CNT;
        end
      end
      S_RUN: begin
        // a second launch mid-run is dropped; the link holds go high
        if (cnt_q == '0) begin
          state_d    = S_IDLE;
          done_tgl_d = ~done_tgl_q;
          result_d   = code_s2_q;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    go_s1_q   <= i_go_tgl;
    go_s2_q   <= go_s1_q;
    code_s1_q <= i_conv_code;
    code_s2_q <= code_s1_q;
    if (!i_rst_n) begin
      state_q    <= S_IDLE;
      cnt_q      <= '0;
      go_s3_q    <= 1'b0;
      done_tgl_q <= 1'b0;
      result_q   <= RES_ZERO;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      go_s3_q    <= go_s2_q;
      done_tgl_q <= done_tgl_d;
      result_q   <= result_d;
    end
  end
endmodule : resistor_sense_timer

// File: rtl/ulpi_vendor_id_sense_regs.sv
// Notes on behaviour
// - set float event flag on enabled rise or fall of the id floating state
// - event latch register is read only; its flags clear when it is read
// - latch bits 1, 2 and 7:4 always read zero
// - set conversion event flag when done rises with interrupt enable on
// - vendor space is 30h to 3Fh, reached by immediate register commands
// - boost field 6:5 of 31h picks hs amplitude; other bits read zero
// - headset audio mode only while key field of 33h holds 1010
// - three-bit result code gives measured id resistance class
// - start bit launches one measurement and clears itself when done
// - done flag rises automatically when the 282 us measurement ends
// - reading conversion register clears done; carkit status read does not
// - result code and done flag are mirrored on o_sense_result_code and o_sense_done; carkit status reads get no ack
// - with enable set, done raises alt_int toward the link
// - effective conversion interrupt enable is own bit or carkit enable bit
// - conversion register reads at 36h-38h; writes load, set and clear
module ulpi_vendor_id_sense_regs
  import vendor_sense_pkg::*;
#(
  parameter int unsigned SENSE_CYCLES_P = SENSE_CYCLES
) (
  // core clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // ulpi link clock
  input  wire logic       i_link_clk,
  // immediate register access, link domain
  input  wire logic       i_reg_wr_stb,
  input  wire logic       i_reg_rd_stb,
  input  wire logic [5:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic            o_reg_hit,
  output logic [7:0]      o_reg_rdata,
  output logic            o_reg_ack,
  // enables held in the carkit interrupt enable register
  input  wire logic       i_float_rise_irq_en,
  input  wire logic       i_float_fall_irq_en,
  input  wire logic       i_kit_sense_irq_en,
  // analogue side
  input  wire logic       i_id_floating,
  input  wire logic [2:0] i_conv_code,
  // controls and indications
  output logic            o_alt_int,
  output logic [1:0]      o_boost,
  output logic            o_headset_audio_en,
  output logic [2:0]      o_sense_result_code,
  output logic            o_sense_done
);
  // ==========================================================
  // helpers
  function automatic logic is_sense_addr(input logic [5:0] a);
    is_sense_addr = (a >= ADDR_SENSE_WR) && (a <= ADDR_SENSE_CLR);
  endfunction : is_sense_addr

  function automatic logic [7:0] alias_apply(input logic [5:0] a, input logic [7:0] cur,
                                             input logic [7:0] w);
    unique case (a)
      ADDR_SENSE_SET: alias_apply = cur | w;
      ADDR_SENSE_CLR: alias_apply = cur & ~w;
      default:        alias_apply = w;
    endcase
  endfunction : alias_apply

  // ==========================================================
  // link-domain reset and crossings
  logic rst_s1_q, rst_s2_q, link_rst_n;
  logic flt_s1_q, flt_s2_q, flt_prev_q;
  logic dn_s1_q, dn_s2_q, dn_s3_q;
  logic done_tgl, arrive;
  logic [2:0] core_result;

  // result from the timer was loaded with its toggle, so it is steady once arrive shows
  assign link_rst_n = rst_s2_q;
  assign arrive     = dn_s2_q ^ dn_s3_q;

  always_ff @(posedge i_link_clk) begin
    rst_s1_q <= i_rst_n;
    rst_s2_q <= rst_s1_q;
    flt_s1_q <= i_id_floating;
    flt_s2_q <= flt_s1_q;
    dn_s1_q  <= done_tgl;
    dn_s2_q  <= dn_s1_q;
    if (!link_rst_n) begin
      // follow the pin in reset: an id already floating at reset
      // must not show up as a rise on the first edge after it
      flt_prev_q <= flt_s2_q;
      dn_s3_q    <= 1'b0;
    end else begin
      flt_prev_q <= flt_s2_q;
      dn_s3_q    <= dn_s2_q;
    end
  end

  // ==========================================================
  // register state
  logic       float_evt_q, float_evt_d;
  logic       sense_evt_q, sense_evt_d;
  logic [1:0] boost_q, boost_d;
  logic [3:0] key_q, key_d;
  logic       audio_en_q, audio_en_d;
  logic [2:0] result_q, result_d;
  logic       done_q, done_d;
  logic       go_q, go_d;
  logic       go_tgl_q, go_tgl_d;
  logic       rsvd5_q, rsvd5_d;
  logic       irq_en_q, irq_en_d;
  logic       alt_q, alt_d;
  logic [7:0] rdata_q, rdata_d;
  logic       ack_q, ack_d;
  logic [7:0] sense_view, sense_new;
  logic       sense_wr, sense_rd, latch_rd, float_hit, sense_hit, irq_eff;

  assign o_reg_hit = (i_reg_addr == ADDR_LATCH) ||
                     ((i_reg_addr >= ADDR_VENDOR_LO) && (i_reg_addr <= ADDR_VENDOR_HI));
  assign sense_view = {1'b0, irq_en_q, rsvd5_q, go_q, done_q, result_q};
  assign sense_wr   = i_reg_wr_stb && is_sense_addr(i_reg_addr);
  assign sense_rd   = i_reg_rd_stb && is_sense_addr(i_reg_addr);
  assign latch_rd   = i_reg_rd_stb && (i_reg_addr == ADDR_LATCH);
  assign sense_new  = alias_apply(i_reg_addr, sense_view, i_reg_wdata);
  assign irq_eff    = irq_en_q | i_kit_sense_irq_en;
  assign float_hit  = (flt_s2_q && !flt_prev_q && i_float_rise_irq_en) ||
                      (!flt_s2_q && flt_prev_q && i_float_fall_irq_en);
  assign sense_hit  = arrive && !done_q && irq_eff;

  always_comb begin
    boost_d  = boost_q;
    key_d    = key_q;
    result_d = result_q;
    go_d     = go_q;
    go_tgl_d = go_tgl_q;
    rsvd5_d  = rsvd5_q;
    irq_en_d = irq_en_q;
    done_d   = done_q;
    if (i_reg_wr_stb && (i_reg_addr == ADDR_BOOST)) begin
      boost_d = i_reg_wdata[BOOST_MSB:BOOST_LSB];
    end
    if (i_reg_wr_stb && (i_reg_addr == ADDR_AUDIO)) begin
      key_d = i_reg_wdata[3:0];
    end
    if (sense_wr) begin
      result_d = sense_new[2:0];
      rsvd5_d  = sense_new[SENSE_RSVD_BIT];
      irq_en_d = sense_new[SENSE_IRQ_BIT];
      go_d     = sense_new[SENSE_GO_BIT];
      // launch travels as a toggle so the slower core clock never misses it
      if (sense_new[SENSE_GO_BIT] && !go_q) begin
        go_tgl_d = ~go_tgl_q;
      end
    end
    // hardware completion wins over a write in the same cycle
    if (sense_rd) begin
      done_d = 1'b0;
    end
    if (arrive) begin
      go_d     = 1'b0;
      done_d   = 1'b1;
      result_d = core_result;
    end
    audio_en_d = (key_d == AUDIO_KEY);
  end

  // ==========================================================
  // event latch and read path
  always_comb begin
    float_evt_d = float_evt_q;
    sense_evt_d = sense_evt_q;
    // set wins over the read clear: an event in the read cycle waits for the next read
    if (latch_rd) begin
      float_evt_d = 1'b0;
      sense_evt_d = 1'b0;
    end
    if (float_hit) begin
      float_evt_d = 1'b1;
    end
    if (sense_hit) begin
      sense_evt_d = 1'b1;
    end
    alt_d   = float_evt_d | sense_evt_d;
    ack_d   = i_reg_rd_stb && o_reg_hit;
    // read data holds until the next read, the link may take it late
    rdata_d = rdata_q;
    if (i_reg_rd_stb) begin
      rdata_d = RESET_BYTE;
      if (latch_rd) begin
        rdata_d[LATCH_FLOAT_BIT] = float_evt_q;
        rdata_d[LATCH_SENSE_BIT] = sense_evt_q;
      end else if (i_reg_addr == ADDR_BOOST) begin
        rdata_d[BOOST_MSB:BOOST_LSB] = boost_q;
      end else if (i_reg_addr == ADDR_AUDIO) begin
        rdata_d[3:0] = key_q;
      end else if (is_sense_addr(i_reg_addr)) begin
        rdata_d = sense_view;
      end
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!link_rst_n) begin
      float_evt_q <= 1'b0;
      sense_evt_q <= 1'b0;
      boost_q     <= BOOST_NOMINAL;
      key_q       <= 4'h0;
      audio_en_q  <= 1'b0;
      result_q    <= RES_ZERO;
      done_q      <= 1'b0;
      go_q        <= 1'b0;
      go_tgl_q    <= 1'b0;
      rsvd5_q     <= 1'b0;
      irq_en_q    <= 1'b0;
      alt_q       <= 1'b0;
      rdata_q     <= RESET_BYTE;
      ack_q       <= 1'b0;
    end else begin
      float_evt_q <= float_evt_d;
      sense_evt_q <= sense_evt_d;
      boost_q     <= boost_d;
      key_q       <= key_d;
      audio_en_q  <= audio_en_d;
      result_q    <= result_d;
      done_q      <= done_d;
      go_q        <= go_d;
      go_tgl_q    <= go_tgl_d;
      rsvd5_q     <= rsvd5_d;
      irq_en_q    <= irq_en_d;
      alt_q       <= alt_d;
      rdata_q     <= rdata_d;
      ack_q       <= ack_d;
    end
  end

  assign o_reg_rdata         = rdata_q;
  assign o_reg_ack           = ack_q;
  assign o_alt_int           = alt_q;
  assign o_boost             = boost_q;
  assign o_headset_audio_en  = audio_en_q;
  assign o_sense_result_code = result_q;
  assign o_sense_done        = done_q;

  // ==========================================================
  // measurement timer on the core clock
  resistor_sense_timer #(
    .SENSE_CYCLES_P(SENSE_CYCLES_P)
  ) u_timer (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_go_tgl   (go_tgl_q),
    .i_conv_code(i_conv_code),
    .o_done_tgl (done_tgl),
    .o_result_q (core_result)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge i_link_clk); endclocking
  default disable iff (!link_rst_n);

  sequence s_launch;
    sense_wr && sense_new[SENSE_GO_BIT] && !go_q && !arrive;
  endsequence
  sequence s_sense_read;
    sense_rd && !arrive;
  endsequence

  a_latch_rsvd_zero: assert property (latch_rd |=>
    (o_reg_rdata[7:4] == 4'h0) && (o_reg_rdata[2:1] == 2'h0))
    else $error("latch unused bits not zero");
  a_latch_rd_clear: assert property (latch_rd && !float_hit && !sense_hit |=>
    !float_evt_q && !sense_evt_q)
    else $error("latch flags survived a read");
  a_event_kept: assert property (float_hit || sense_hit |=>
    float_evt_q || sense_evt_q)
    else $error("event lost");
  a_float_rise: assert property (flt_s2_q && !flt_prev_q && i_float_rise_irq_en |=>
    float_evt_q)
    else $error("float rise not latched");
  a_sense_event: assert property (arrive && !done_q && i_kit_sense_irq_en |=>
    sense_evt_q && o_alt_int)
    else $error("conversion event or alt_int missing");
  a_boost_load: assert property (i_reg_wr_stb && i_reg_addr == ADDR_BOOST |=>
    o_boost == $past(i_reg_wdata[6:5]))
    else $error("boost field not loaded");
  a_audio_key: assert property (i_reg_wr_stb && i_reg_addr == ADDR_AUDIO &&
    i_reg_wdata[3:0] == AUDIO_KEY |=> o_headset_audio_en)
    else $error("audio mode not entered on key");
  a_go_launch: assert property (s_launch |=>
    go_q && (go_tgl_q != $past(go_tgl_q)))
    else $error("measurement not launched");
  a_go_done: assert property (arrive |=> !go_q && o_sense_done)
    else $error("completion not reflected");
  a_done_rd_clear: assert property (s_sense_read |=> !o_sense_done)
    else $error("done not cleared by read");
  a_status_keep: assert property (i_reg_rd_stb && i_reg_addr == ADDR_KIT_STATUS &&
    done_q |=> done_q)
    else $error("status read cleared done");
  a_set_alias: assert property (i_reg_wr_stb && i_reg_addr == ADDR_SENSE_SET &&
    i_reg_wdata[SENSE_IRQ_BIT] |=> irq_en_q)
    else $error("set alias failed");
  a_clr_alias: assert property (i_reg_wr_stb && i_reg_addr == ADDR_SENSE_CLR &&
    i_reg_wdata[6] |=> !irq_en_q)
    else $error("clear alias failed");
endmodule : ulpi_vendor_id_sense_regs
